// File: hw/iat_top.sv
// iat_top: addressing and transaction setup registers of a two-wire controller/target
// assumes an axi4-lite master on clk and a bit engine on the same clock
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps

// What this block does
// - force stop bit makes a STOP condition
// - own 7-bit address, reset 0x55
// - extension gives upper bits in 10-bit mode
// - data setup lasts field minus one cycles
// - direction bit: zero write, one read
// - seven-bit destination address in descriptor
// - destination extension gives upper 10-bit bits
// - start-byte bit prefixes start byte procedure
// - type 00 sends general call only
// - type 01 seven-bit, 10 ten-bit address
// - stop-after bit chooses STOP or repeated START
// - length sets bytes; read NACKs last byte
module iat_top
	import iat_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 nrst,
	// axi4-lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// bit engine side
	input  wire logic                 hdr_ready,
	output logic [7:0]                hdr_byte,
	output logic                      hdr_valid,
	output logic                      force_stop,
	output logic                      xfer_read,
	output logic                      stop_after,
	output logic [IAT_LEN_W-1:0]      xfer_len,
	input  wire logic                 rx_byte_done,
	output logic                      nack_last,
	input  wire logic [9:0]           rx_addr,
	input  wire logic                 rx_addr_valid,
	output logic                      addr_match,
	input  wire logic                 stretch_release,
	output logic                      setup_busy
);
	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic                 own_mode10;
	logic [6:0]           own_addr_low;
	logic [2:0]           own_addr_ext;
	logic [15:0]          target_setup_cycles;
	logic [6:0]           dest_addr_low;
	logic [2:0]           dest_addr_ext;
	logic                 start_byte_prefix;
	logic [1:0]           addr_type;
	logic                 xfer_start;
	logic [IAT_LEN_W-1:0] rx_count;
	logic [IAT_LEN_W-1:0] next_rx_count;
	logic [7:0]           aw_addr;
	logic                 aw_held;
	logic [31:0]          w_data;
	logic [3:0]           w_strb;
	logic                 w_held;
	logic                 wr_do;
	logic                 wr_hit;
	logic [31:0]          wr_word;
	logic [31:0]          rd_word;
	logic                 rd_hit;

	// ------------------------------------------------------------
	// axi write: address and data taken in either order
	// ------------------------------------------------------------
	assign wr_do = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			aw_held       <= 1'b0;
			aw_addr       <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held       <= 1'b1;
			aw_addr       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else begin
			if (wr_do) begin
				aw_held <= 1'b0;
			end
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			w_held       <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held       <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else begin
			if (wr_do) begin
				w_held <= 1'b0;
			end
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= IAT_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? IAT_RESP_OKAY : IAT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// byte-lane merge of write data with the register's current value
	// ------------------------------------------------------------
	always_comb begin
		wr_hit  = 1'b1;
		wr_word = 32'h00000000;
		case (aw_addr)
			IAT_OFF_CTRL: wr_word = {16'h0000, force_stop, 14'h0000, own_mode10};
			IAT_OFF_OWN:  wr_word = {target_setup_cycles, 6'h00, own_addr_ext, own_addr_low};
			IAT_OFF_DESC: wr_word = {6'h00, xfer_len, stop_after, addr_type, start_byte_prefix,
				dest_addr_ext, dest_addr_low, xfer_read};
			default:      wr_hit  = 1'b0;
		endcase
		for (int i = 0; i < 4; i++) begin
			if (w_strb[i]) begin
				wr_word[i*8 +: 8] = w_data[i*8 +: 8];
			end
		end
	end

	// control register: force stop held until software clears it
	always_ff @(posedge clk) begin
		if (!nrst) begin
			own_mode10 <= 1'b0;
			force_stop <= 1'b0;
		end else if (wr_do && aw_addr == IAT_OFF_CTRL) begin
			own_mode10 <= wr_word[IAT_CTRL_MODE10];
			force_stop <= wr_word[IAT_CTRL_FSTOP];
		end
	end

	// own address configuration
	always_ff @(posedge clk) begin
		if (!nrst) begin
			own_addr_low        <= IAT_OWN_LOW_RST;
			own_addr_ext        <= IAT_OWN_EXT_RST;
			target_setup_cycles <= IAT_OWN_SETUP_RST;
		end else if (wr_do && aw_addr == IAT_OFF_OWN) begin
			own_addr_low        <= wr_word[IAT_OWN_LOW_LSB +: 7];
			own_addr_ext        <= wr_word[IAT_OWN_EXT_LSB +: 3];
			target_setup_cycles <= wr_word[IAT_OWN_SETUP_LSB +: 16];
		end
	end

	// descriptor; a write to it launches the transaction header
	always_ff @(posedge clk) begin
		if (!nrst) begin
			xfer_read         <= 1'b0;
			dest_addr_low     <= 7'h00;
			dest_addr_ext     <= 3'h0;
			start_byte_prefix <= 1'b0;
			addr_type         <= 2'b00;
			stop_after        <= 1'b0;
			xfer_len          <= '0;
			xfer_start        <= 1'b0;
		end else begin
			xfer_start <= wr_do && aw_addr == IAT_OFF_DESC;
			if (wr_do && aw_addr == IAT_OFF_DESC) begin
				xfer_read         <= wr_word[IAT_DESC_DIR];
				dest_addr_low     <= wr_word[IAT_DESC_LOW +: 7];
				dest_addr_ext     <= wr_word[IAT_DESC_EXT +: 3];
				start_byte_prefix <= wr_word[IAT_DESC_SB];
				addr_type         <= wr_word[IAT_DESC_TYPE +: 2];
				stop_after        <= wr_word[IAT_DESC_STOP];
				xfer_len          <= wr_word[IAT_DESC_LEN +: IAT_LEN_W];
			end
		end
	end

	// ------------------------------------------------------------
	// axi read: one-cycle answer, unmapped reads give zero and slverr
	// ------------------------------------------------------------
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h00000000;
		case (s_axi_araddr)
			IAT_OFF_CTRL:   rd_word = {16'h0000, force_stop, 14'h0000, own_mode10};
			IAT_OFF_OWN:    rd_word = {target_setup_cycles, 6'h00, own_addr_ext, own_addr_low};
			IAT_OFF_DESC:   rd_word = {6'h00, xfer_len, stop_after, addr_type,
				start_byte_prefix, dest_addr_ext, dest_addr_low, xfer_read};
			IAT_OFF_STATUS: rd_word = {5'h00, rx_count, 12'h000, addr_match, nack_last,
				setup_busy, hdr_valid};
			default:        rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= IAT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? IAT_RESP_OKAY : IAT_RESP_SLVERR;
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
		end
	end

	// ------------------------------------------------------------
	// own address match; 10-bit form puts the extension on top
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			addr_match <= 1'b0;
		end else if (rx_addr_valid) begin
			addr_match <= own_mode10 ? (rx_addr == {own_addr_ext, own_addr_low})
			                         : (rx_addr[6:0] == own_addr_low);
		end
	end

	// ------------------------------------------------------------
	// received byte count; the flag marks the byte that must be nacked
	// ------------------------------------------------------------
	assign next_rx_count = xfer_start ? '0 :
		(rx_byte_done ? rx_count + IAT_LEN_W'(1) : rx_count);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_count  <= '0;
			nack_last <= 1'b0;
		end else begin
			rx_count  <= next_rx_count;
			nack_last <= xfer_read && xfer_len != '0 &&
				next_rx_count == xfer_len - IAT_LEN_W'(1);
		end
	end

	// ------------------------------------------------------------
	// header bytes and setup timing
	// ------------------------------------------------------------
	iat_header_seq u_seq (
		.clk       (clk),
		.nrst      (nrst),
		.start     (xfer_start),
		.sb        (start_byte_prefix),
		.addr_type (addr_type),
		.dir       (xfer_read),
		.low       (dest_addr_low),
		.ext       (dest_addr_ext),
		.hdr_ready (hdr_ready),
		.hdr_byte  (hdr_byte),
		.hdr_valid (hdr_valid)
	);

	iat_setup_timer #(.W(16)) u_setup (
		.clk           (clk),
		.nrst          (nrst),
		.release_pulse (stretch_release),
		.setup_field   (target_setup_cycles),
		.busy          (setup_busy)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	force_stop_set_a: assert property (
		wr_do && aw_addr == IAT_OFF_CTRL && w_strb[1] |=> force_stop == $past(w_data[15]))
		else $error("force stop not taken from write");
	own_low_match_a: assert property (
		rx_addr_valid && !own_mode10 && rx_addr[6:0] == own_addr_low |=> addr_match)
		else $error("seven-bit own address not matched");
	own_ext_match_a: assert property (
		rx_addr_valid && own_mode10 && rx_addr[9:7] != own_addr_ext |=> !addr_match)
		else $error("ten-bit match ignored extension");
	setup_len_a: assert property (
		stretch_release && target_setup_cycles == 16'h0005 |=> setup_busy[*4] ##1 !setup_busy)
		else $error("setup hold not field minus one");
	dir_bit_a: assert property (
		xfer_start && addr_type == IAT_AT_SEVEN && !start_byte_prefix && !hdr_valid
		|=> hdr_byte == {dest_addr_low, xfer_read})
		else $error("seven-bit header byte wrong");
	ten_first_a: assert property (
		xfer_start && addr_type == IAT_AT_TEN && !start_byte_prefix && !hdr_valid
		|=> hdr_byte == {IAT_TEN_PREFIX, dest_addr_ext[2:1], xfer_read})
		else $error("ten-bit first header byte wrong");
	// second byte follows the taken prefix byte; a slow engine only stretches the wait
	ten_second_a: assert property (
		hdr_valid && hdr_ready && addr_type == IAT_AT_TEN &&
		hdr_byte == {IAT_TEN_PREFIX, dest_addr_ext[2:1], xfer_read}
		|=> hdr_byte == {dest_addr_ext[0], dest_addr_low})
		else $error("ten-bit second header byte wrong");
	start_byte_a: assert property (
		xfer_start && start_byte_prefix && !hdr_valid |=> hdr_valid && hdr_byte == IAT_START_BYTE)
		else $error("start byte not prefixed");
	gen_call_a: assert property (
		xfer_start && addr_type == IAT_AT_GENCALL && !start_byte_prefix && !hdr_valid
		|=> hdr_valid && hdr_byte == IAT_GENCALL_BYTE)
		else $error("general call byte wrong");
	stop_after_a: assert property (
		wr_do && aw_addr == IAT_OFF_DESC && w_strb[1] |=> stop_after == $past(w_data[14]))
		else $error("stop-after bit not taken");
	nack_last_a: assert property (
		xfer_read && !xfer_start && rx_byte_done && rx_count + IAT_LEN_W'(2) == xfer_len
		|=> nack_last)
		else $error("last read byte not flagged for nack");

	read_cov: cover property (s_axi_rvalid && s_axi_rready);
	write_desc_cov: cover property (xfer_start ##[1:4] hdr_valid && hdr_ready);
	ten_bit_cov: cover property (xfer_start && addr_type == IAT_AT_TEN);
	setup_cov: cover property ($fell(setup_busy));
endmodule

// File: hw/iat_pkg.sv
// iat_pkg: offsets, field positions, reset values and encodings of the i2c addressing block
// assumes a 32-bit axi4-lite register bus and byte addresses as offsets
package iat_pkg;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] IAT_OFF_CTRL   = 8'h00;
	localparam logic [7:0] IAT_OFF_OWN    = 8'h04;
	localparam logic [7:0] IAT_OFF_DESC   = 8'h0C;
	localparam logic [7:0] IAT_OFF_STATUS = 8'h14;
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int IAT_CTRL_MODE10 = 0;   // own address is 10-bit
	localparam int IAT_CTRL_FSTOP  = 15;  // force stop
	// ------------------------------------------------------------
	// own address register fields and reset values
	// ------------------------------------------------------------
	localparam int IAT_OWN_LOW_LSB   = 0;
	localparam int IAT_OWN_EXT_LSB   = 7;
	localparam int IAT_OWN_SETUP_LSB = 16;
	localparam logic [6:0]  IAT_OWN_LOW_RST   = 7'h55;
	localparam logic [2:0]  IAT_OWN_EXT_RST   = 3'h0;
	localparam logic [15:0] IAT_OWN_SETUP_RST = 16'h000F;
	// ------------------------------------------------------------
	// transaction descriptor fields
	// ------------------------------------------------------------
	localparam int IAT_DESC_DIR   = 0;
	localparam int IAT_DESC_LOW   = 1;
	localparam int IAT_DESC_EXT   = 8;
	localparam int IAT_DESC_SB    = 11;
	localparam int IAT_DESC_TYPE  = 12;
	localparam int IAT_DESC_STOP  = 14;
	localparam int IAT_DESC_LEN   = 15;
	localparam int IAT_LEN_W      = 11;
	// ------------------------------------------------------------
	// header bytes and encodings
	// ------------------------------------------------------------
	localparam logic [7:0] IAT_START_BYTE   = 8'h01;
	localparam logic [7:0] IAT_GENCALL_BYTE = 8'h00;
	localparam logic [4:0] IAT_TEN_PREFIX   = 5'h1E;
	localparam logic [1:0] IAT_RESP_OKAY    = 2'h0;
	localparam logic [1:0] IAT_RESP_SLVERR  = 2'h2;
	typedef enum logic [1:0] {
		IAT_AT_GENCALL = 2'b00,
		IAT_AT_SEVEN   = 2'b01,
		IAT_AT_TEN     = 2'b10
	} iat_addr_type;
endpackage

// File: hw/iat_setup_timer.sv
// iat_setup_timer: counts the data setup time that follows a clock stretch
// assumes release is a one-cycle pulse on clk from the bit engine
`timescale 1ns/1ps
module iat_setup_timer
	import iat_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         release_pulse,
	input  wire logic [W-1:0] setup_field,
	output logic              busy
);
	logic [W-1:0] count;

	// ------------------------------------------------------------
	// countdown: field minus one cycles; 0 or 1 gives no hold
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			count <= '0;
			busy  <= 1'b0;
		end else if (release_pulse && setup_field > W'(1)) begin
			count <= setup_field - W'(2); // busy now runs field-1 cycles
			busy  <= 1'b1;
		end else if (count != '0) begin
			count <= count - W'(1);
		end else begin
			busy <= 1'b0;
		end
	end
endmodule

// File: hw/iat_header_seq.sv
// iat_header_seq: emits the header bytes that open a controller transaction
// assumes the bit engine takes a byte when hdr_valid and hdr_ready are both high
`timescale 1ns/1ps
module iat_header_seq
	import iat_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       start,
	input  wire logic       sb,
	input  wire logic [1:0] addr_type,
	input  wire logic       dir,
	input  wire logic [6:0] low,
	input  wire logic [2:0] ext,
	input  wire logic       hdr_ready,
	output logic [7:0]      hdr_byte,
	output logic            hdr_valid
);
	typedef enum logic [2:0] {
		IAT_S_IDLE  = 3'b000,
		IAT_S_SBYTE = 3'b001,
		IAT_S_ADDR1 = 3'b010,
		IAT_S_ADDR2 = 3'b011
	} iat_seq_type;

	iat_seq_type state;
	logic [9:0]  addr10;
	logic [7:0]  first_byte;

	// extension sits above the low field
	assign addr10 = {ext, low};

	// ------------------------------------------------------------
	// first address byte by address type
	// ------------------------------------------------------------
	always_comb begin
		case (addr_type)
			IAT_AT_GENCALL: first_byte = IAT_GENCALL_BYTE;
			IAT_AT_TEN:     first_byte = {IAT_TEN_PREFIX, addr10[9:8], dir};
			default:        first_byte = {low, dir};
		endcase
	end

	// ------------------------------------------------------------
	// byte sequence; start is ignored while a header is under way
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state     <= IAT_S_IDLE;
			hdr_byte  <= 8'h00;
			hdr_valid <= 1'b0;
		end else begin
			case (state)
				IAT_S_IDLE: begin
					if (start) begin
						hdr_valid <= 1'b1;
						hdr_byte  <= sb ? IAT_START_BYTE : first_byte;
						state     <= sb ? IAT_S_SBYTE : IAT_S_ADDR1;
					end
				end
				IAT_S_SBYTE: begin
					if (hdr_ready) begin
						hdr_byte <= first_byte;
						state    <= IAT_S_ADDR1;
					end
				end
				IAT_S_ADDR1: begin
					if (hdr_ready) begin
						if (addr_type == IAT_AT_TEN) begin
							hdr_byte <= addr10[7:0];
							state    <= IAT_S_ADDR2;
						end else begin
							hdr_valid <= 1'b0;
							state     <= IAT_S_IDLE;
						end
					end
				end
				IAT_S_ADDR2: begin
					if (hdr_ready) begin
						hdr_valid <= 1'b0;
						state     <= IAT_S_IDLE;
					end
				end
				default: begin
					hdr_valid <= 1'b0;
					state     <= IAT_S_IDLE;
				end
			endcase
		end
	end
endmodule

// File: sim/iat_engine_model.sv
// iat_engine_model: bit engine and bus-side stand-in for the addressing block
// assumes it shares clk with the block and is driven through its tasks
`timescale 1ns/1ps
module iat_engine_model (
	input  wire logic       clk,
	input  wire logic [7:0] hdr_byte,
	input  wire logic       hdr_valid,
	output logic            hdr_ready,
	output logic            rx_byte_done,
	output logic [9:0]      rx_addr,
	output logic            rx_addr_valid,
	output logic            stretch_release
);
	logic [7:0] got[$];
	logic       slow = 1'h0;
	initial begin
		hdr_ready = 1'h0;
		rx_byte_done = 1'h0;
		rx_addr = 10'h000;
		rx_addr_valid = 1'h0;
		stretch_release = 1'h0;
	end
	// a slow engine accepts every other cycle, so the block must hold its byte
	always @(posedge clk) begin
		if (hdr_valid && hdr_ready)
			got.push_back(hdr_byte);
		hdr_ready <= slow ? !hdr_ready : 1'h1;
	end
	task pulse_rx;
		rx_byte_done <= 1'h1;
		@(posedge clk);
		rx_byte_done <= 1'h0;
	endtask
	// outside its pulse the address bus shows garbage, never the last value
	task send_addr(input logic [9:0] a);
		rx_addr <= a;
		rx_addr_valid <= 1'h1;
		@(posedge clk);
		rx_addr <= ~a;
		rx_addr_valid <= 1'h0;
	endtask
	task release_stretch;
		stretch_release <= 1'h1;
		@(posedge clk);
		stretch_release <= 1'h0;
	endtask
endmodule

// File: sim/i2c_addressing_and_transaction_setup_bench.sv
// i2c_addressing_and_transaction_setup_bench: self-checking bench for iat_top
// assumes iat_pkg and the engine model are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("Error %0t got %h exp %h", $time, g, e); \
	end \
end
module i2c_addressing_and_transaction_setup_bench;
	import iat_pkg::*;
	logic                 clk = 1'h0;
	logic                 nrst = 1'h0;
	logic [7:0]           s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, hdr_byte;
	logic [31:0]          s_axi_wdata = 32'h0, s_axi_rdata, q;
	logic [3:0]           s_axi_wstrb = 4'hF;
	logic                 s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic                 s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [1:0]           s_axi_bresp, s_axi_rresp, r;
	logic                 s_axi_rvalid, hdr_ready, hdr_valid, force_stop, xfer_read;
	logic                 stop_after, rx_byte_done, nack_last, rx_addr_valid;
	logic                 addr_match, stretch_release, setup_busy;
	logic [IAT_LEN_W-1:0] xfer_len;
	logic [9:0]           rx_addr;
	int                   miscompares = 0;
	int                   n_compared = 0;
	iat_top dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .hdr_ready, .hdr_byte, .hdr_valid, .force_stop, .xfer_read, .stop_after,
		.xfer_len, .rx_byte_done, .nack_last, .rx_addr, .rx_addr_valid, .addr_match,
		.stretch_release, .setup_busy);
	iat_engine_model eng (.clk, .hdr_byte, .hdr_valid, .hdr_ready, .rx_byte_done, .rx_addr,
		.rx_addr_valid, .stretch_release);
	// 25 ns clock
	always #12.5 clk = ~clk;
	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	// response ready goes up with the request; one idle edge closes each
	// task so no signal is driven twice in one step; a hang is left to the watchdog
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rr);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready === 1'h1)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1)
				s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready === 1'h1)
				s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge clk);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task hdr(input logic [31:0] d, input int n, input logic [23:0] e);
		int t;
		eng.got.delete();
		wr(IAT_OFF_DESC, d, r);
		for (t = 0; t < 40 && eng.got.size() < n; t++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		`CHK(eng.got.size(), n)
		for (t = 0; t < n; t++)
			`CHK(eng.got[t], e[8*(n-1-t)+:8])
		`CHK(hdr_valid, 1'h0)
	endtask
	task setup_chk(input logic [15:0] f, input int e);
		int c;
		c = 0;
		wr(IAT_OFF_OWN, {f, 16'h0055}, r);
		eng.release_stretch();
		repeat (20) begin
			@(posedge clk);
			if (setup_busy === 1'h1)
				c++;
		end
		`CHK(c, e)
		`CHK(setup_busy, 1'h0)
	endtask
	task addr_chk(input logic [9:0] a, input logic e);
		eng.send_addr(a);
		repeat (2) @(posedge clk);
		`CHK(addr_match, e)
	endtask
	// ------------------------------------------------------------
	// closing
	// ------------------------------------------------------------
	task results;
		if (miscompares == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// a hang costs far more than the few hundred cycles of the run
	initial begin
		#500000;
		miscompares++;
		results();
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		@(posedge clk);
		rd(IAT_OFF_OWN, q, r);
		`CHK(q, 32'h000F0055)
		rd(IAT_OFF_DESC, q, r);
		`CHK(q, 32'h00000000)
		rd(8'h08, q, r);
		`CHK({r, q}, {IAT_RESP_SLVERR, 32'h0})
		wr(8'h10, 32'hFFFFFFFF, r);
		`CHK(r, IAT_RESP_SLVERR)
		wr(IAT_OFF_CTRL, 32'h00008000, r);
		`CHK(force_stop, 1'h1)
		wr(IAT_OFF_CTRL, 32'h00000000, r);
		`CHK(force_stop, 1'h0)
		addr_chk(10'h055, 1'h1);
		addr_chk(10'h054, 1'h0);
		// lanes 0 and 1 only: setup field must survive the write
		s_axi_wstrb <= 4'h3;
		wr(IAT_OFF_OWN, 32'hFFFF01A1, r);
		s_axi_wstrb <= 4'hF;
		rd(IAT_OFF_OWN, q, r);
		`CHK(q, 32'h000F01A1)
		wr(IAT_OFF_CTRL, 32'h00000001, r);
		addr_chk(10'h1A1, 1'h1);
		addr_chk(10'h121, 1'h0);
		setup_chk(16'h0005, 4);
		setup_chk(16'h0003, 2);
		setup_chk(16'h0001, 0);
		hdr(32'h000050B5, 1, 24'h0000B5);
		// general call with direction and address set: both must be ignored
		hdr(32'h000000FF, 1, 24'h000000);
		hdr(32'h000008FF, 2, 24'h000100);
		hdr(32'h00002566, 2, 24'h00F4B3);
		eng.slow = 1'h1;
		hdr(32'h00002A1F, 3, 24'h01F30F);
		eng.slow = 1'h0;
		wr(IAT_OFF_DESC, 32'h0001D0B5, r);
		`CHK({xfer_read, stop_after, xfer_len}, {2'h3, 11'h003})
		`CHK(nack_last, 1'h0)
		eng.pulse_rx();
		repeat (3) @(posedge clk);
		`CHK(nack_last, 1'h0)
		eng.pulse_rx();
		repeat (3) @(posedge clk);
		`CHK(nack_last, 1'h1)
		// status: two bytes counted, nack pending, nothing else active
		rd(IAT_OFF_STATUS, q, r);
		`CHK(q, 32'h00020004)
		wr(IAT_OFF_DESC, 32'h000090B4, r);
		`CHK({xfer_read, stop_after, nack_last}, 3'h0)
		results();
	end
endmodule
